/* rtl/bccc_defs.svh */
// Overview of operation
// - pack above voltage plus margin suspends
// - fast charge requests stored fast current
// - termination zero, then maintenance current
// - low voltage or cool temperature precharges
// - current at or over request plus margin zeroes
// - maximum temperature suspends charging
// - hysteresis or 43.0 degrees clears overtemperature
// - overcharge past full suspends fast charge
// - state of charge clears full flag
// - sync option loads capacity at termination
// - discharged threshold increments cycle count
// - taper qualified forty seconds terminates
// - balance on threshold, differential, interval
// - led source absolute or relative
// - led count field selects segments
// - two bits append error code byte
// - inhibit bit blocks all broadcasts
// - cell count field: four or three
// - compensation bit picks fixed or computed
// - source bit picks cell or pack
// - overvoltage source pack or cells times count
// - midrange correction enable bit
`ifndef BCCC_DEFS_SVH
`define BCCC_DEFS_SVH
// register indexes; byte address is four times the index
`define BCCC_IDX_CYCLE 8'h0C
`define BCCC_IDX_PACK 8'h28
`define BCCC_IDX_GAUGE 8'h29
`define BCCC_IDX_CYC_THR 8'h37
`define BCCC_IDX_CHG_V 8'h39
`define BCCC_IDX_PRE_V 8'h3B
`define BCCC_IDX_FAST_I 8'h3D
`define BCCC_IDX_MAINT_I 8'h3F
`define BCCC_IDX_PRE_I 8'h41
`define BCCC_IDX_PRE_T 8'h43
`define BCCC_IDX_FULL_CLR 8'h47
`define BCCC_IDX_TAPER_I 8'h48
`define BCCC_IDX_TAPER_V 8'h4A
`define BCCC_IDX_OVERCHG 8'h4E
`define BCCC_IDX_MAX_T 8'h53
`define BCCC_IDX_HYST 8'h55
`define BCCC_IDX_OV_MRG 8'h5A
`define BCCC_IDX_OC_MRG 8'h5C
`define BCCC_IDX_TERM_PCT 8'h60
`define BCCC_IDX_SAFE_V 8'h61
`define BCCC_IDX_STATUS 8'h62
`define BCCC_IDX_REQ_I 8'h63
`define BCCC_IDX_END_DISCHARGE_THRESHOLD_ZERO 8'h84
`define BCCC_IDX_BAL_THR 8'hD9
`define BCCC_IDX_BAL_MIN 8'hDB
`define BCCC_IDX_BAL_INT 8'hDC
// option byte bit positions
`define BCCC_PK_LED_SRC 7
`define BCCC_PK_LED_HI 6
`define BCCC_PK_LED_LO 5
`define BCCC_PK_HOST_PEC 4
`define BCCC_PK_CHG_PEC 3
`define BCCC_PK_INHIBIT 2
`define BCCC_PK_CELL_HI 1
`define BCCC_PK_CELL_LO 0
`define BCCC_GC_SYNC 6
`define BCCC_GC_EDV_COMP 4
`define BCCC_GC_EDV_SRC 3
`define BCCC_GC_OV_SRC 2
`define BCCC_GC_MIDRANGE 1
// reset values and fixed figures
`define BCCC_RST_WORD 16'h0000
`define BCCC_BAL_OFF 16'hFFFF
`define BCCC_T_CLEAR_DC 16'sd430
`define BCCC_TAPER_S 6'd40
`define BCCC_CLK_NS 4
`define BCCC_SEC_NS 1000000000
`endif

/* rtl/bccc_pkg.sv */
package bccc_pkg;
	// measurements delivered by the gauge core, same clock
	typedef struct packed {
		logic [15:0] pack_mv;
		logic [15:0] cell_max_mv;
		logic [15:0] cell_min_mv;
		logic signed [15:0] current_ma;
		logic signed [15:0] temp_dc;
		logic [7:0] rsoc;
		logic [15:0] over_full_mah;
		logic [15:0] fcc;
		logic [15:0] end_discharge_threshold_zero_calc;
		logic dsg_mah;
		logic [15:0] safe_v;
	} bccc_meas_type;
	// decoded option outputs
	typedef struct packed {
		logic led_relative;
		logic [2:0] led_segments;
		logic host_pec;
		logic charger_pec;
		logic broadcast_en;
		logic [2:0] series_cells;
		logic edv_computed;
		logic edv_pack_basis;
		logic midrange_en;
		logic safety_ov;
	} bccc_opt_type;
	// complete block state
	typedef struct packed {
		logic [25:0][15:0] cfg;
		logic [7:0] a_idx;
		logic a_wr;
		logic a_vld;
		logic [31:0] rdata;
		logic [15:0] cycle;
		logic [15:0] dsg_acc;
		logic [15:0] chg_cur;
		logic ot;
		logic oc;
		logic term;
		logic full;
		logic [27:0] tdiv;
		logic [5:0] tsec;
		logic [27:0] bdiv;
		logic [7:0] bsec;
		logic bal;
		logic rm_ld;
		logic [15:0] rm_val;
	} bccc_state_type;
endpackage

/* rtl/bccc_top.sv */
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ps
`include "bccc_defs.svh"
module bccc_top #(
	parameter int SEC_CYCLES = `BCCC_SEC_NS / `BCCC_CLK_NS
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// gauge measurements and battery mode broadcast bit
	input wire bccc_pkg::bccc_meas_type meas,
	input wire logic mode_bcast_en,
	// charge control results
	output logic [15:0] charging_current,
	output logic full_charged,
	output logic [15:0] cycle_count,
	output logic balance_on,
	output logic rm_load,
	output logic [15:0] rm_load_value,
	output bccc_pkg::bccc_opt_type opts
);
	import bccc_pkg::*;
	localparam logic [4:0] NOSLOT = 5'h1F;
	localparam logic [27:0] SEC_LAST = 28'(SEC_CYCLES - 1);

	// index to storage slot, NOSLOT when not a stored word
	function automatic logic [4:0] slot_of(input logic [7:0] idx);
		unique case (idx)
			`BCCC_IDX_PACK: slot_of = 5'h00;
			`BCCC_IDX_GAUGE: slot_of = 5'h01;
			`BCCC_IDX_CYC_THR: slot_of = 5'h02;
			`BCCC_IDX_CHG_V: slot_of = 5'h03;
			`BCCC_IDX_PRE_V: slot_of = 5'h04;
			`BCCC_IDX_FAST_I: slot_of = 5'h05;
			`BCCC_IDX_MAINT_I: slot_of = 5'h06;
			`BCCC_IDX_PRE_I: slot_of = 5'h07;
			`BCCC_IDX_PRE_T: slot_of = 5'h08;
			`BCCC_IDX_FULL_CLR: slot_of = 5'h09;
			`BCCC_IDX_TAPER_I: slot_of = 5'h0A;
			`BCCC_IDX_TAPER_V: slot_of = 5'h0B;
			`BCCC_IDX_OVERCHG: slot_of = 5'h0C;
			`BCCC_IDX_MAX_T: slot_of = 5'h0D;
			`BCCC_IDX_HYST: slot_of = 5'h0E;
			`BCCC_IDX_OV_MRG: slot_of = 5'h0F;
			`BCCC_IDX_OC_MRG: slot_of = 5'h10;
			`BCCC_IDX_TERM_PCT: slot_of = 5'h11;
			`BCCC_IDX_SAFE_V: slot_of = 5'h12;
			`BCCC_IDX_END_DISCHARGE_THRESHOLD_ZERO: slot_of = 5'h13;
			`BCCC_IDX_BAL_THR: slot_of = 5'h14;
			`BCCC_IDX_BAL_MIN: slot_of = 5'h15;
			`BCCC_IDX_BAL_INT: slot_of = 5'h16;
			default: slot_of = NOSLOT;
		endcase
	endfunction

	// byte-wide slots keep only the low eight bits
	function automatic logic [15:0] mask_of(input logic [4:0] s);
		unique case (s)
			5'h00, 5'h01, 5'h08, 5'h09, 5'h0B, 5'h0E, 5'h11, 5'h15, 5'h16: mask_of = 16'h00FF;
			default: mask_of = 16'hFFFF;
		endcase
	endfunction

	bccc_state_type st_r; // registered state
	bccc_state_type st_nxt; // next state
	logic [15:0] pack_b; // pack option byte
	logic [15:0] gauge_b; // gauge option byte
	logic [16:0] ov_lim; // overvoltage limit
	logic [16:0] oc_lim; // overcurrent limit
	logic ov_now; // overvoltage present
	logic oc_hit; // overcurrent seen this cycle
	logic ot_set; // at or above maximum temperature
	logic ot_clr; // cooled enough to release
	logic ochg; // overcharge past full
	logic suspend; // any suspension active
	logic charging; // positive current flows in
	logic pre_cond; // precharge wanted
	logic tq; // taper qualification
	logic taper_ev; // taper termination pulse
	logic cyc_hit; // discharge threshold reached
	logic bal_ok; // balance start condition
	logic sec_tick; // one-second enable
	logic [15:0] end_discharge_threshold_zero; // effective lowest threshold
	logic [15:0] edv_basis; // voltage compared to it
	logic [11:0] hyst_dc; // hysteresis in tenths
	logic [24:0] rm_prod; // capacity times fraction
	logic [16:0] safe_cmp; // value compared for safety
	logic [2:0] cells; // series cell count
	logic a_take; // address phase accepted
	logic [7:0] a_idx; // word index of address
	logic [4:0] rs; // slot of read index
	logic [4:0] ws; // slot of pending write

	assign pack_b = st_r.cfg[0];
	assign gauge_b = st_r.cfg[1];
	assign a_idx = haddr[9:2];
	assign rs = slot_of(a_idx);
	assign ws = slot_of(st_r.a_idx);
	// zero wait states; every access answers okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign a_take = hsel && hready && htrans[1] && (hsize == 3'h2) && (haddr[31:10] == 22'h0);
	assign charging = !meas.current_ma[15] && (meas.current_ma != 16'sd0);

	assign cells = ({pack_b[`BCCC_PK_CELL_HI], pack_b[`BCCC_PK_CELL_LO]} == 2'h1) ? 3'd3 : 3'd4;
	assign end_discharge_threshold_zero = gauge_b[`BCCC_GC_EDV_COMP] ? meas.end_discharge_threshold_zero_calc : st_r.cfg[19];
	assign edv_basis = gauge_b[`BCCC_GC_EDV_SRC] ? meas.pack_mv : meas.cell_min_mv;

	// suspension and selection conditions
	always_comb begin
		ov_lim = {1'b0, st_r.cfg[3]} + {1'b0, st_r.cfg[15]};
		ov_now = charging && ({1'b0, meas.pack_mv} > ov_lim);
		oc_lim = {1'b0, st_r.chg_cur} + {1'b0, st_r.cfg[16]};
		oc_hit = charging && ({1'b0, meas.current_ma} >= oc_lim);
		ot_set = meas.temp_dc >= $signed(st_r.cfg[13]);
		hyst_dc = 12'(st_r.cfg[14][7:0] * 8'd10);
		ot_clr = (meas.temp_dc <= $signed(st_r.cfg[13] - {4'h0, hyst_dc}))
			|| (meas.temp_dc <= `BCCC_T_CLEAR_DC);
		ochg = meas.over_full_mah > st_r.cfg[12];
		suspend = ov_now || st_r.oc || st_r.ot || ochg;
		pre_cond = (edv_basis < end_discharge_threshold_zero) || (meas.pack_mv < st_r.cfg[4])
			|| ((meas.temp_dc > 16'sd0) && (meas.temp_dc < $signed({8'h0, st_r.cfg[8][7:0]})));
		tq = charging && ({1'b0, meas.pack_mv} + {9'h0, st_r.cfg[11][7:0]} >= {1'b0, st_r.cfg[3]})
			&& (meas.current_ma < $signed(st_r.cfg[10]));
		bal_ok = (st_r.cfg[20] != `BCCC_BAL_OFF) && (meas.cell_max_mv >= st_r.cfg[20])
			&& ((meas.cell_max_mv - meas.cell_min_mv) >= {8'h0, st_r.cfg[21][7:0]});
	end

	assign sec_tick = (st_r.bdiv == SEC_LAST);
	assign taper_ev = tq && !st_r.term && (st_r.tdiv == SEC_LAST) && (st_r.tsec == `BCCC_TAPER_S - 6'd1);
	assign cyc_hit = meas.dsg_mah && (st_r.cfg[2] != 16'h0) && (st_r.dsg_acc + 16'h1 >= st_r.cfg[2]);
	// fraction is (code + 1) / 256
	assign rm_prod = meas.fcc * {1'b0, st_r.cfg[17][7:0]} + {9'h0, meas.fcc};
	// pack or highest cell times count
	assign safe_cmp = gauge_b[`BCCC_GC_OV_SRC] ? 17'(meas.cell_max_mv * cells) : {1'b0, meas.pack_mv};

	// next-state logic for bus, protection and counters
	always_comb begin
		st_nxt = st_r;
		st_nxt.rm_ld = 1'b0;
		// address phase capture; reads are served from flops
		st_nxt.a_vld = a_take;
		if (a_take) begin
			st_nxt.a_idx = a_idx;
			st_nxt.a_wr = hwrite;
		end
		if (a_take && !hwrite) begin
			if (rs != NOSLOT)
				st_nxt.rdata = {16'h0, st_r.cfg[rs]};
			else if (a_idx == `BCCC_IDX_CYCLE)
				st_nxt.rdata = {16'h0, st_r.cycle};
			else if (a_idx == `BCCC_IDX_STATUS)
				st_nxt.rdata = {26'h0, st_r.bal, st_r.term, st_r.full, st_r.oc, st_r.ot, suspend};
			else if (a_idx == `BCCC_IDX_REQ_I)
				st_nxt.rdata = {16'h0, st_r.chg_cur};
			else
				st_nxt.rdata = 32'h0;
		end
		// data phase write; unmapped indexes are dropped
		if (st_r.a_vld && st_r.a_wr) begin
			if (ws != NOSLOT)
				st_nxt.cfg[ws] = hwdata[15:0] & mask_of(ws);
		end
		// overcurrent holds until charge current stops
		if (oc_hit)
			st_nxt.oc = 1'b1;
		else if (!charging)
			st_nxt.oc = 1'b0;
		// over-temperature latch, set wins over clear
		if (ot_set)
			st_nxt.ot = 1'b1;
		else if (ot_clr)
			st_nxt.ot = 1'b0;
		// taper timer restarts whenever qualification drops
		if (!tq || st_r.term) begin
			st_nxt.tdiv = 28'h0;
			st_nxt.tsec = 6'h0;
		end else if (st_r.tdiv == SEC_LAST) begin
			st_nxt.tdiv = 28'h0;
			st_nxt.tsec = st_r.tsec + 6'h1;
		end else
			st_nxt.tdiv = st_r.tdiv + 28'h1;
		// full flag falls at the clear level, termination wins
		if (taper_ev) begin
			st_nxt.full = 1'b1;
			st_nxt.term = 1'b1;
		end else if (st_r.full && (meas.rsoc <= st_r.cfg[9][7:0])) begin
			st_nxt.full = 1'b0;
			st_nxt.term = 1'b0;
		end
		if (taper_ev && gauge_b[`BCCC_GC_SYNC]) begin
			st_nxt.rm_ld = 1'b1;
			st_nxt.rm_val = rm_prod[23:8];
		end
		// cycle counting, a write preloads the count
		if (cyc_hit) begin
			st_nxt.dsg_acc = 16'h0;
			st_nxt.cycle = st_r.cycle + 16'h1;
		end else if (meas.dsg_mah)
			st_nxt.dsg_acc = st_r.dsg_acc + 16'h1;
		if (st_r.a_vld && st_r.a_wr && (st_r.a_idx == `BCCC_IDX_CYCLE))
			st_nxt.cycle = hwdata[15:0];
		st_nxt.bdiv = sec_tick ? 28'h0 : st_r.bdiv + 28'h1;
		if (sec_tick)
			st_nxt.bsec = (st_r.bsec + 8'h1 >= st_r.cfg[22][7:0]) ? 8'h0 : st_r.bsec + 8'h1;
		if (st_r.cfg[20] == `BCCC_BAL_OFF)
			st_nxt.bal = 1'b0;
		else if (sec_tick && (st_r.bsec == 8'h0))
			st_nxt.bal = bal_ok;
		if (suspend || st_r.oc)
			st_nxt.chg_cur = 16'h0;
		// zero while taper holds, then maintenance
		else if (st_r.term || taper_ev)
			st_nxt.chg_cur = (tq || taper_ev) ? 16'h0 : st_r.cfg[6];
		else if (pre_cond)
			st_nxt.chg_cur = st_r.cfg[7];
		else
			st_nxt.chg_cur = st_r.cfg[5];
	end

	// single state register; configuration resets to zero, balance off
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= '0;
			st_r.cfg[20] <= `BCCC_BAL_OFF;
		end else
			st_r <= st_nxt;
	end

	assign hrdata = st_r.rdata;
	assign charging_current = st_r.chg_cur;
	assign full_charged = st_r.full;
	assign cycle_count = st_r.cycle;
	assign balance_on = st_r.bal;
	assign rm_load = st_r.rm_ld;
	assign rm_load_value = st_r.rm_val;

	// option decodes from the stored bytes; broadcast also needs the mode bit, safety_ov compares measurements
	always_comb begin
		opts.led_relative = pack_b[`BCCC_PK_LED_SRC];
		// segment count, both outer codes give five
		unique case ({pack_b[`BCCC_PK_LED_HI], pack_b[`BCCC_PK_LED_LO]})
			2'h1: opts.led_segments = 3'd3;
			2'h2: opts.led_segments = 3'd4;
			default: opts.led_segments = 3'd5;
		endcase
		opts.host_pec = pack_b[`BCCC_PK_HOST_PEC];
		opts.charger_pec = pack_b[`BCCC_PK_CHG_PEC];
		// mode bits cannot override the inhibit
		opts.broadcast_en = !pack_b[`BCCC_PK_INHIBIT] && mode_bcast_en;
		opts.series_cells = cells;
		opts.edv_computed = gauge_b[`BCCC_GC_EDV_COMP];
		opts.edv_pack_basis = gauge_b[`BCCC_GC_EDV_SRC];
		opts.midrange_en = gauge_b[`BCCC_GC_MIDRANGE];
		opts.safety_ov = safe_cmp > {1'b0, meas.safe_v};
	end

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_oc_caught;
		oc_hit ##1 st_r.oc;
	endsequence
	property p_ov_zero;
		ov_now |=> charging_current == 16'h0;
	endproperty
	a_ov_zero: assert property (p_ov_zero) else $error("overvoltage left current on");
	property p_fast;
		!suspend && !st_r.oc && !st_r.term && !taper_ev && !pre_cond |=> charging_current == $past(st_r.cfg[5]);
	endproperty
	a_fast: assert property (p_fast) else $error("fast current wrong");
	property p_term;
		taper_ev && !suspend && !st_r.oc |=> charging_current == 16'h0 ##1 st_r.term;
	endproperty
	a_term: assert property (p_term) else $error("termination did not zero current");
	property p_pre;
		pre_cond && !suspend && !st_r.oc && !st_r.term && !taper_ev |=> charging_current == $past(st_r.cfg[7]);
	endproperty
	a_pre: assert property (p_pre) else $error("precharge current wrong");
	property p_oc;
		s_oc_caught |=> charging_current == 16'h0;
	endproperty
	a_oc: assert property (p_oc) else $error("overcurrent left current on");
	property p_ot;
		ot_set |=> st_r.ot ##1 charging_current == 16'h0;
	endproperty
	a_ot: assert property (p_ot) else $error("overtemperature not held");
	property p_ot_rel;
		st_r.ot && !ot_set && meas.temp_dc <= `BCCC_T_CLEAR_DC |=> !st_r.ot;
	endproperty
	a_ot_rel: assert property (p_ot_rel) else $error("overtemperature not released");
	property p_cycle;
		cyc_hit && !(st_r.a_vld && st_r.a_wr) |=> cycle_count == $past(cycle_count) + 16'h1;
	endproperty
	a_cycle: assert property (p_cycle) else $error("cycle count missed");
	property p_bal_off;
		st_r.cfg[20] == `BCCC_BAL_OFF |=> !balance_on;
	endproperty
	a_bal_off: assert property (p_bal_off) else $error("balance ran while disabled");
	property p_ochg;
		ochg |=> charging_current == 16'h0;
	endproperty
	a_ochg: assert property (p_ochg) else $error("overcharge left current on");
	property p_full_clr;
		st_r.full && !taper_ev && (meas.rsoc <= st_r.cfg[9][7:0]) |=> !full_charged;
	endproperty
	a_full_clr: assert property (p_full_clr) else $error("full flag not cleared");
	property p_sync;
		taper_ev && gauge_b[`BCCC_GC_SYNC] |=> rm_load ##1 !rm_load;
	endproperty
	a_sync: assert property (p_sync) else $error("capacity load pulse wrong");
	property p_bcast;
		pack_b[`BCCC_PK_INHIBIT] |-> !opts.broadcast_en;
	endproperty
	a_bcast: assert property (p_bcast) else $error("broadcast on while inhibited");
endmodule

/* verif/bccc_gauge_model.sv */
`timescale 1ns/1ps
// gauge core stand-in: holds the measurements and makes discharge pulses
module bccc_gauge_model (
	// clock
	hclk,
	// measurements handed to the block
	meas
);
	import bccc_pkg::*;
	input wire logic hclk;
	output bccc_pkg::bccc_meas_type meas;
	// one single-cycle pulse per mAh, with a gap so pulses never merge
	task automatic discharge(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge hclk);
			meas.dsg_mah <= 1'b1;
			@(posedge hclk);
			meas.dsg_mah <= 1'b0;
		end
	endtask
	// a healthy mid-charge pack at room temperature
	initial begin
		meas = '0;
		meas.pack_mv = 16'd11000;
		meas.cell_max_mv = 16'd3700;
		meas.cell_min_mv = 16'd3700;
		meas.temp_dc = 16'sd250;
		meas.rsoc = 8'd50;
		meas.fcc = 16'd4000;
	end
endmodule

/* verif/testbench.sv */
`timescale 1ns/1ps
`include "bccc_defs.svh"
module testbench;
	import bccc_pkg::*;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, mode_bcast_en = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 0;
	logic hready, hresp, full_charged, balance_on, rm_load;
	logic [15:0] charging_current, cycle_count, rm_load_value;
	bccc_meas_type meas;
	bccc_opt_type opts;
	int bad_count = 0, n_checks = 0, cyc = 0, seen, first;
	// short second keeps the forty-second taper inside the run
	localparam int SEC = 10;
	always #2 hclk = ~hclk;
	bccc_gauge_model gm (.hclk(hclk), .meas(meas));
	// single slave: its hreadyout is the bus hready
	bccc_top #(.SEC_CYCLES(SEC)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .meas(meas),
		.mode_bcast_en(mode_bcast_en), .charging_current(charging_current),
		.full_charged(full_charged), .cycle_count(cycle_count), .balance_on(balance_on),
		.rm_load(rm_load), .rm_load_value(rm_load_value), .opts(opts));
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// hang guard
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			report_and_stop();
		end
	end
	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	// one single word transfer; address phase then data phase, no assumed latency
	task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {22'h0, idx, 2'h0};
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [15:0] d);
		bus(1'b1, idx, {16'h0, d});
	endtask
	// sample away from the launching edge
	task automatic go(input int n);
		repeat (n) @(negedge hclk);
	endtask
	task automatic cc(input logic [15:0] e);
		go(4);
		chk("charging_current", charging_current, e);
		// leave on a rising edge so the next stimulus lands there
		@(posedge hclk);
	endtask
	task automatic t_regs();
		chk("reset current", charging_current, 16'h0000);
		bus(1'b0, `BCCC_IDX_PACK, 32'h0);
		chk("pack reset", rd, 32'h0);
		chk("hresp", hresp, 1'b0);
		wr(8'h70, 16'h1234);
		bus(1'b0, 8'h70, 32'h0);
		chk("unmapped", rd, 32'h0);
		wr(`BCCC_IDX_TAPER_V, 16'hABCD);
		bus(1'b0, `BCCC_IDX_TAPER_V, 32'h0);
		chk("byte word", rd, 32'h000000CD);
		$display("test regs done");
	endtask
	task automatic t_charge();
		wr(`BCCC_IDX_TAPER_V, 16'd100);
		wr(`BCCC_IDX_MAX_T, 16'd600);
		wr(`BCCC_IDX_CHG_V, 16'd12600);
		wr(`BCCC_IDX_FAST_I, 16'd2000);
		wr(`BCCC_IDX_MAINT_I, 16'd100);
		wr(`BCCC_IDX_PRE_I, 16'd300);
		wr(`BCCC_IDX_OV_MRG, 16'd100);
		wr(`BCCC_IDX_OC_MRG, 16'd500);
		wr(`BCCC_IDX_HYST, 16'd2);
		wr(`BCCC_IDX_TAPER_I, 16'd200);
		wr(`BCCC_IDX_OVERCHG, 16'd500);
		wr(`BCCC_IDX_END_DISCHARGE_THRESHOLD_ZERO, 16'd3600);
		gm.meas.current_ma <= 16'sd1500;
		cc(16'd2000);
		gm.meas.current_ma <= 16'sd2500;
		cc(16'd0);
		// the overcurrent latch only lets go once charge current stops
		gm.meas.current_ma <= 16'sd0;
		repeat (2) @(posedge hclk);
		// overvoltage counts only while charging; stay below the current margin
		gm.meas.current_ma <= 16'sd400;
		gm.meas.pack_mv <= 16'd12701;
		cc(16'd0);
		gm.meas.pack_mv <= 16'd12700;
		cc(16'd2000);
		gm.meas.over_full_mah <= 16'd501;
		cc(16'd0);
		gm.meas.over_full_mah <= 16'd500;
		cc(16'd2000);
		bus(1'b0, `BCCC_IDX_REQ_I, 32'h0);
		chk("request readback", rd, 32'd2000);
		gm.meas.current_ma <= 16'sd0;
		$display("test charge done");
	endtask
	task automatic t_pre();
		wr(`BCCC_IDX_PRE_V, 16'd9000);
		gm.meas.pack_mv <= 16'd8999;
		cc(16'd300);
		gm.meas.pack_mv <= 16'd9000;
		cc(16'd2000);
		gm.meas.cell_min_mv <= 16'd3599;
		cc(16'd300);
		wr(`BCCC_IDX_GAUGE, 16'h0008);
		cc(16'd2000);
		gm.meas.cell_min_mv <= 16'd3700;
		gm.meas.pack_mv <= 16'd11000;
		wr(`BCCC_IDX_GAUGE, 16'h0000);
		wr(`BCCC_IDX_PRE_T, 16'd100);
		gm.meas.temp_dc <= 16'sd50;
		cc(16'd300);
		gm.meas.temp_dc <= 16'sd150;
		cc(16'd2000);
		$display("test precharge done");
	endtask
	task automatic t_temp();
		gm.meas.temp_dc <= 16'sd600;
		cc(16'd0);
		gm.meas.temp_dc <= 16'sd590;
		cc(16'd0);
		gm.meas.temp_dc <= 16'sd580;
		cc(16'd2000);
		wr(`BCCC_IDX_MAX_T, 16'd440);
		wr(`BCCC_IDX_HYST, 16'd10);
		cc(16'd0);
		gm.meas.temp_dc <= 16'sd431;
		cc(16'd0);
		gm.meas.temp_dc <= 16'sd430;
		cc(16'd2000);
		wr(`BCCC_IDX_MAX_T, 16'd600);
		gm.meas.temp_dc <= 16'sd250;
		$display("test temperature done");
	endtask
	task automatic t_taper();
		wr(`BCCC_IDX_FULL_CLR, 16'd90);
		wr(`BCCC_IDX_TERM_PCT, 16'h00F9);
		wr(`BCCC_IDX_GAUGE, 16'h0040);
		gm.meas.rsoc <= 8'd100;
		gm.meas.pack_mv <= 16'd12550;
		gm.meas.current_ma <= 16'sd150;
		seen = 0;
		first = 0;
		for (int i = 0; i < 40 * SEC + 50; i++) begin
			go(1);
			if (rm_load === 1'b1 && seen == 0) begin
				first = i;
				seen = 1;
			end
		end
		chk("rm_load seen", seen, 1);
		chk("taper not early", first >= 40 * SEC - 4, 1);
		chk("rm_load_value", rm_load_value, 16'd3906);
		chk("full_charged", full_charged, 1'b1);
		cc(16'd0);
		gm.meas.current_ma <= 16'sd250;
		cc(16'd100);
		gm.meas.rsoc <= 8'd90;
		go(4);
		chk("full cleared", full_charged, 1'b0);
		@(posedge hclk);
		gm.meas.pack_mv <= 16'd11000;
		gm.meas.current_ma <= 16'sd0;
		cc(16'd2000);
		$display("test taper done");
	endtask
	task automatic t_cycle();
		wr(`BCCC_IDX_CYC_THR, 16'd3);
		wr(`BCCC_IDX_CYCLE, 16'd5);
		gm.discharge(2);
		go(3);
		chk("cycle_count", cycle_count, 16'd5);
		gm.discharge(1);
		go(3);
		chk("cycle_count", cycle_count, 16'd6);
		$display("test cycle done");
	endtask
	task automatic t_opts();
		@(posedge hclk);
		mode_bcast_en <= 1'b1;
		// four cells of 3700 mV exceed this, the 11000 mV pack does not
		gm.meas.safe_v <= 16'd12000;
		for (int c = 0; c < 4; c++) begin
			wr(`BCCC_IDX_PACK, 16'(16'h9D | (c << 5)));
			go(2);
			chk("led_segments", opts.led_segments, (c == 1) ? 3 : (c == 2) ? 4 : 5);
		end
		bus(1'b0, `BCCC_IDX_PACK, 32'h0);
		chk("pack readback", rd, 32'hFD);
		chk("on opts", {opts.led_relative, opts.host_pec, opts.charger_pec}, 3'h7);
		chk("series_cells", opts.series_cells, 3'd3);
		mode_bcast_en <= 1'b0;
		repeat (2) @(posedge hclk);
		mode_bcast_en <= 1'b1;
		go(2);
		chk("broadcast_en", opts.broadcast_en, 1'b0);
		wr(`BCCC_IDX_PACK, 16'h0000);
		go(2);
		chk("off opts", {opts.led_relative, opts.host_pec, opts.charger_pec}, 3'h0);
		chk("broadcast_en", opts.broadcast_en, 1'b1);
		chk("series_cells", opts.series_cells, 3'd4);
		wr(`BCCC_IDX_GAUGE, 16'h001E);
		go(2);
		chk("gauge opts", {opts.edv_computed, opts.edv_pack_basis, opts.midrange_en}, 3'h7);
		chk("safety_ov", opts.safety_ov, 1'b1);
		wr(`BCCC_IDX_GAUGE, 16'h0000);
		go(2);
		chk("gauge opts", {opts.edv_computed, opts.edv_pack_basis, opts.midrange_en}, 3'h0);
		chk("safety_ov", opts.safety_ov, 1'b0);
		$display("test options done");
	endtask
	task automatic t_bal();
		@(posedge hclk);
		gm.meas.cell_min_mv <= 16'd3650;
		wr(`BCCC_IDX_BAL_MIN, 16'd10);
		wr(`BCCC_IDX_BAL_INT, 16'd1);
		go(3 * SEC);
		chk("balance off", balance_on, 1'b0);
		wr(`BCCC_IDX_BAL_THR, 16'd3600);
		seen = 0;
		for (int i = 0; i < 5 * SEC && seen == 0; i++) begin
			go(1);
			if (balance_on === 1'b1) seen = 1;
		end
		chk("balance on", seen, 1);
		wr(`BCCC_IDX_BAL_THR, 16'hFFFF);
		go(3 * SEC);
		chk("balance disabled", balance_on, 1'b0);
		$display("test balance done");
	endtask
	initial begin
		go(3);
		chk("current in reset", charging_current, 16'h0000);
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs();
		t_charge();
		t_pre();
		t_temp();
		t_taper();
		t_cycle();
		t_opts();
		t_bal();
		report_and_stop();
	end
endmodule
